// *** common/mms_pkg.sv ***
// Shared constants and types for the MII management link ends
package mms_pkg;

    // ************************************************************
    // Clock rates
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS     = 25;
    localparam int unsigned MDC_MAX_MHZ       = 5;
    localparam int unsigned MDC_MIN_PERIOD_NS = 1000 / MDC_MAX_MHZ;
    // Least period rounds up to whole system clock cycles
    localparam int unsigned MDC_DIV_CYC =
        (MDC_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Frame layout, counted in management clock bits
    // ************************************************************
    localparam logic [5:0] PRE_CNT       = 6'h20;
    localparam logic [5:0] OP_LAST       = 6'h01;
    localparam logic [5:0] ADDR_LAST     = 6'h09;
    localparam logic [5:0] TA_LAST       = 6'h01;
    localparam logic [5:0] DATA_LAST     = 6'h0F;
    localparam logic [5:0] FRAME_LAST    = 6'h3F;
    localparam logic [5:0] RD_RELEASE    = 6'h2E;
    localparam logic [5:0] RD_DATA_FIRST = 6'h30;
    localparam logic [31:0] PREAMBLE     = 32'hFFFFFFFF;
    localparam logic [1:0] START_PAT     = 2'h1;
    localparam logic [1:0] OP_RD         = 2'h2;
    localparam logic [1:0] OP_WR         = 2'h1;
    localparam logic [1:0] TA_WR         = 2'h2;
    localparam logic [1:0] TA_RD         = 2'h3;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [4:0]  REG_CTRL     = 5'h00;
    localparam logic [4:0]  REG_STAT     = 5'h01;
    localparam logic [4:0]  REG_ID_HI    = 5'h02;
    localparam logic [4:0]  REG_ID_LO    = 5'h03;
    localparam logic [4:0]  REG_STD_LAST = 5'h05;
    localparam logic [4:0]  REG_VND_A    = 5'h1D;
    localparam logic [4:0]  REG_VND_B    = 5'h1F;
    localparam logic [2:0]  SLOT_VND_A   = 3'h6;
    localparam logic [2:0]  SLOT_VND_B   = 3'h7;
    localparam int unsigned NUM_SLOTS    = 8;
    localparam logic [15:0] REG_RST_VAL  = 16'h0000;

    // ************************************************************
    // State encodings
    // ************************************************************
    typedef enum logic [2:0] {
        DS_PRE = 3'h0,
        DS_ST  = 3'h1,
        DS_OP  = 3'h3,
        DS_ADR = 3'h2,
        DS_TA  = 3'h6,
        DS_DAT = 3'h7
    } mms_dev_state_t;

    typedef enum logic {
        SS_IDLE = 1'b0,
        SS_RUN  = 1'b1
    } mms_sta_state_t;

endpackage : mms_pkg

// *** common/mms_if.sv ***
// Two-wire management link between station and device
`timescale 1ns/1ps
interface mms_if;
    logic mdc;
    logic sta_o;
    logic sta_oe;
    logic dev_o;
    logic dev_oe;
    logic mdio;

    // Shared data line with a pull-up when nobody drives
    assign mdio = sta_oe ? sta_o : (dev_oe ? dev_o : 1'b1);

    modport dev (input mdc, input mdio, output dev_o, output dev_oe);
    modport sta (output mdc, output sta_o, output sta_oe, input mdio);
endinterface : mms_if

// *** logic/mms_device.sv ***
// Management slave end: frame decoder, PHY register bank, user crossing
`timescale 1ns/1ps
// ************************************************************
// What this block does
// RULE1: Slave of the standard two-wire management interface
// RULE2: Station originates every read and write frame
// RULE3: Clock from station, one data line shared
// RULE4: Eight 16-bit registers: 0..5, 29, 31
// RULE5: Management clock at most 5 MHz
// RULE6: Read frame: preamble, 01, 10, addresses, Z0, data
// RULE7: Write frame: preamble, 01, 01, addresses, 10, data
// RULE8: Sample on rising edge, drive just after it
// ************************************************************
module mms_device
    import mms_pkg::*;
#(
    parameter logic [4:0]  PHY_ADDR = 5'h01,
    parameter logic [15:0] ID_HI    = 16'h1234, // Arbitrary value
    parameter logic [15:0] ID_LO    = 16'h5678  // Arbitrary value
) (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    mms_if.dev               link,
    input  wire logic [15:0] i_stat,
    output logic             o_wr_valid,
    output logic [4:0]       o_wr_reg,
    output logic [15:0]      o_wr_data
);

    // ************************************************************
    // Register slot decode
    // ************************************************************
    // Returns {valid, slot}
    function automatic logic [3:0] reg_slot(input logic [4:0] ra);
        logic [3:0] r;
        r = 4'h0;
        if (ra <= REG_STD_LAST) begin
            r = {1'b1, ra[2:0]};
        end else if (ra == REG_VND_A) begin
            r = {1'b1, SLOT_VND_A};
        end else if (ra == REG_VND_B) begin
            r = {1'b1, SLOT_VND_B};
        end
        return r;
    endfunction : reg_slot

    // ************************************************************
    // Link-domain reset and status crossing
    // ************************************************************
    logic [1:0]     lrst_q;
    logic           lrst;
    logic           lreq_q;
    logic [2:0]     lack_q;
    logic           lmask;
    logic [15:0]    stat_q;
    logic [15:0]    stat_m_q;
    logic [15:0]    stat_s_q;

    // Management clock runs only in frames: hold the request until seen
    always_ff @(posedge i_clk) begin
        lack_q <= {lack_q[1:0], lrst};
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lreq_q <= 1'b1;
        end else if (lack_q[1] && lack_q[2]) begin
            lreq_q <= 1'b0;
        end
    end

    always_ff @(posedge link.mdc) begin
        lrst_q <= {lrst_q[0], lreq_q};
    end
    assign lrst  = lrst_q[1];
    // Keeps the data line released until the link side is out of reset
    assign lmask = lreq_q || lack_q[1] || lack_q[2];

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            stat_q <= 16'h0000;
        end else begin
            stat_q <= i_stat;
        end
    end

    // Status bits are quasi-static, each crossing on its own
    always_ff @(posedge link.mdc) begin
        stat_m_q <= stat_q;
        stat_s_q <= stat_m_q;
    end

    // ************************************************************
    // Frame decoder, clocked by the management clock
    // ************************************************************
    mms_dev_state_t state_q;
    logic [5:0]     cnt_q;
    logic [1:0]     op_q;
    logic [9:0]     adr_q;
    logic [15:0]    wd_q;
    logic           bit_i;
    logic           hit;
    logic [3:0]     slot;

    assign bit_i = link.mdio;
    assign hit   = (adr_q[9:5] == PHY_ADDR);
    assign slot  = reg_slot(adr_q[4:0]); // [RULE4]

    // Rate independent: every step is one management clock edge [RULE5]
    always_ff @(posedge link.mdc) begin
        if (lrst) begin
            state_q <= DS_PRE;
            cnt_q   <= 6'h00;
        end else begin
            unique case (state_q)
                DS_PRE: begin
                    if (!bit_i) begin
                        cnt_q <= 6'h00;
                        if (cnt_q == PRE_CNT) begin
                            state_q <= DS_ST; // [RULE6]
                        end
                    end else if (cnt_q != PRE_CNT) begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                DS_ST: begin
                    cnt_q   <= 6'h00;
                    state_q <= bit_i ? DS_OP : DS_PRE;
                end
                DS_OP: begin
                    if (cnt_q == OP_LAST) begin
                        cnt_q <= 6'h00;
                        if ({op_q[0], bit_i} == OP_RD ||
                            {op_q[0], bit_i} == OP_WR) begin
                            state_q <= DS_ADR; // [RULE1]
                        end else begin
                            state_q <= DS_PRE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                DS_ADR: begin
                    if (cnt_q == ADDR_LAST) begin
                        cnt_q   <= 6'h00;
                        state_q <= DS_TA;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                DS_TA: begin
                    if (cnt_q == TA_LAST) begin
                        cnt_q   <= 6'h00;
                        state_q <= DS_DAT;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                DS_DAT: begin
                    if (cnt_q == DATA_LAST) begin
                        cnt_q   <= 6'h00;
                        state_q <= DS_PRE; // [RULE6]
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                default: begin
                    cnt_q   <= 6'h00;
                    state_q <= DS_PRE;
                end
            endcase
        end
    end

    // Opcode, address and write data are taken on rising edges [RULE8]
    always_ff @(posedge link.mdc) begin
        if (lrst) begin
            op_q  <= 2'h0;
            adr_q <= 10'h000;
            wd_q  <= 16'h0000;
        end else begin
            if (state_q == DS_OP) begin
                op_q <= {op_q[0], bit_i};
            end
            if (state_q == DS_ADR) begin
                adr_q <= {adr_q[8:0], bit_i};
            end
            if (state_q == DS_DAT) begin
                wd_q <= {wd_q[14:0], bit_i}; // [RULE7]
            end
        end
    end

    // ************************************************************
    // Register bank
    // ************************************************************
    logic [15:0] regs_q [NUM_SLOTS];
    logic [15:0] rd_word;
    logic        wr_hit;

    // Status and identity words are read-only; writes to them are dropped
    assign wr_hit = (state_q == DS_DAT) && (cnt_q == DATA_LAST) && hit &&
                    (op_q == OP_WR) && slot[3] &&
                    slot[2:0] != REG_STAT[2:0] &&
                    slot[2:0] != REG_ID_HI[2:0] &&
                    slot[2:0] != REG_ID_LO[2:0];

    always_comb begin
        rd_word = 16'h0000;
        if (slot[3]) begin
            unique case (slot[2:0])
                REG_STAT[2:0]:  rd_word = stat_s_q;
                REG_ID_HI[2:0]: rd_word = ID_HI;
                REG_ID_LO[2:0]: rd_word = ID_LO;
                default:        rd_word = regs_q[slot[2:0]];
            endcase
        end
    end

    always_ff @(posedge link.mdc) begin
        if (lrst) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                regs_q[i] <= REG_RST_VAL;
            end
        end else if (wr_hit) begin
            regs_q[slot[2:0]] <= {wd_q[14:0], bit_i}; // [RULE4]
        end
    end

    // ************************************************************
    // Data line driver for reads
    // ************************************************************
    logic        oe_q;
    logic        out_q;
    logic [15:0] sh_q;

    // Turnaround: first bit left to the pull, second driven low [RULE3]
    always_ff @(posedge link.mdc) begin
        if (lrst) begin
            oe_q  <= 1'b0;
            out_q <= 1'b1;
            sh_q  <= 16'h0000;
        end else if (state_q == DS_TA && cnt_q == 6'h00) begin
            oe_q  <= hit && (op_q == OP_RD); // [RULE6]
            out_q <= 1'b0;
            sh_q  <= rd_word;
        end else if (state_q == DS_TA || state_q == DS_DAT) begin
            out_q <= sh_q[15]; // [RULE8]
            sh_q  <= {sh_q[14:0], 1'b0};
            if (state_q == DS_DAT && cnt_q == DATA_LAST) begin
                oe_q <= 1'b0; // [RULE6]
            end
        end
    end

    assign link.dev_o  = out_q;
    assign link.dev_oe = oe_q && !lmask;

    // ************************************************************
    // Write notification to the system clock domain
    // ************************************************************
    logic        wtgl_q;
    logic [4:0]  wreg_q;
    logic [15:0] wdat_q;
    logic [2:0]  wsync_q;
    logic        vld_q;
    logic [4:0]  oreg_q;
    logic [15:0] odat_q;

    always_ff @(posedge link.mdc) begin
        if (lrst) begin
            wtgl_q <= 1'b0;
            wreg_q <= 5'h00;
            wdat_q <= 16'h0000;
        end else if (wr_hit) begin
            wtgl_q <= ~wtgl_q;
            wreg_q <= adr_q[4:0];
            wdat_q <= {wd_q[14:0], bit_i};
        end
    end

    // Word stays stable for a whole frame after the toggle moves
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wsync_q <= 3'h0;
            vld_q   <= 1'b0;
            oreg_q  <= 5'h00;
            odat_q  <= 16'h0000;
        end else begin
            wsync_q <= {wsync_q[1:0], wtgl_q};
            vld_q   <= wsync_q[1] ^ wsync_q[2];
            if (wsync_q[1] ^ wsync_q[2]) begin
                oreg_q <= wreg_q;
                odat_q <= wdat_q;
            end
        end
    end

    assign o_wr_valid = vld_q;
    assign o_wr_reg   = oreg_q;
    assign o_wr_data  = odat_q;

endmodule : mms_device

// *** logic/mms_station.sv ***
// Management station end: clock divider and frame shifter
`timescale 1ns/1ps
module mms_station
    import mms_pkg::*;
#(
    parameter int unsigned MDC_DIV = MDC_DIV_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_start,
    input  wire logic        i_write,
    input  wire logic [4:0]  i_phy,
    input  wire logic [4:0]  i_reg,
    input  wire logic [15:0] i_wdata,
    output logic             o_ready,
    output logic             o_done,
    output logic [15:0]      o_rdata,
    mms_if.sta               link
);

    // Clock must stay at or below the limit and have two equal halves
    if (MDC_DIV < MDC_DIV_CYC || MDC_DIV % 2 != 0 || MDC_DIV > 255) begin
        : g_chk
        $error("MDC_DIV out of range");
    end

    localparam logic [7:0] PH_LAST = 8'(MDC_DIV - 1);
    localparam logic [7:0] PH_HIGH = 8'(MDC_DIV / 2);

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    mms_sta_state_t state_q;
    logic [7:0]     ph_q;
    logic [5:0]     bit_q;
    logic [63:0]    frame_q;
    logic           wr_q;
    logic           done_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= SS_IDLE;
            ph_q    <= 8'h00;
            bit_q   <= 6'h00;
            frame_q <= 64'h0;
            wr_q    <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                SS_IDLE: begin
                    if (i_start) begin
                        state_q <= SS_RUN; // [RULE2]
                        ph_q    <= 8'h00;
                        bit_q   <= 6'h00;
                        wr_q    <= i_write;
                        frame_q <= i_write ?
                            {PREAMBLE, START_PAT, OP_WR, i_phy, i_reg,
                             TA_WR, i_wdata} : // [RULE7]
                            {PREAMBLE, START_PAT, OP_RD, i_phy, i_reg,
                             TA_RD, 16'hFFFF}; // [RULE6]
                    end
                end
                SS_RUN: begin
                    if (ph_q == PH_LAST) begin
                        ph_q    <= 8'h00;
                        bit_q   <= bit_q + 6'h01;
                        frame_q <= {frame_q[62:0], 1'b1};
                        if (bit_q == FRAME_LAST) begin
                            state_q <= SS_IDLE;
                            done_q  <= 1'b1;
                        end
                    end else begin
                        ph_q <= ph_q + 8'h01;
                    end
                end
            endcase
        end
    end

    assign o_ready = (state_q == SS_IDLE);
    assign o_done  = done_q;

    // ************************************************************
    // Clock and data line drive
    // ************************************************************
    logic mdc_q;
    logic out_q;
    logic oe_q;

    // Data changes with the falling edge, clock high in the second half
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mdc_q <= 1'b0;
            out_q <= 1'b1;
            oe_q  <= 1'b0;
        end else if (state_q == SS_RUN) begin
            if (ph_q == 8'h00) begin
                mdc_q <= 1'b0;
                out_q <= frame_q[63];
                oe_q  <= wr_q || (bit_q < RD_RELEASE); // [RULE3]
            end else if (ph_q == PH_HIGH) begin
                mdc_q <= 1'b1; // [RULE5]
            end
        end else begin
            // Idle: clock low and line released one edge after the frame
            mdc_q <= 1'b0;
            oe_q  <= 1'b0; // [RULE7]
        end
    end

    assign link.mdc    = mdc_q;
    assign link.sta_o  = out_q;
    assign link.sta_oe = oe_q;

    // ************************************************************
    // Read data capture
    // ************************************************************
    logic [2:0]  sync_q;
    logic        din_q;
    logic [15:0] rd_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync_q <= 3'h7;
            din_q  <= 1'b1;
            rd_q   <= 16'h0000;
        end else begin
            sync_q <= {sync_q[1:0], link.mdio};
            if (sync_q[1] == sync_q[2]) begin
                din_q <= sync_q[2];
            end
            if (state_q == SS_RUN && !wr_q && ph_q == PH_HIGH &&
                bit_q >= RD_DATA_FIRST) begin
                rd_q <= {rd_q[14:0], din_q}; // [RULE6]
            end
        end
    end

    assign o_rdata = rd_q;

endmodule : mms_station

// *** test/mms_props.sv ***
// Concurrent checks on the signals of the management link
`timescale 1ns/1ps
module mms_props (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic mdc,
    input wire logic sta_o,
    input wire logic sta_oe,
    input wire logic dev_o,
    input wire logic dev_oe
);
    // ********************
    // Management clock rises since the station took the line
    // ********************
    logic       mdc_q;
    logic       sta_oe_q;
    logic [6:0] rise_cnt_q;

    always_ff @(posedge i_clk) begin
        mdc_q    <= mdc;
        sta_oe_q <= sta_oe;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rise_cnt_q <= 7'h00;
        end else if (sta_oe && !sta_oe_q) begin
            rise_cnt_q <= 7'h00;
        end else if (mdc && !mdc_q) begin
            rise_cnt_q <= rise_cnt_q + 7'h01;
        end
    end

    // ********************
    // Sequences
    // ********************
    sequence data_hold_s;
        dev_oe [*8] ##1 dev_oe [*8] ##1 !dev_oe;
    endsequence

    sequence mdc_high_s;
        mdc [*3] ##1 !mdc;
    endsequence

    // ********************
    // Assertions
    // ********************
    no_contention_a: assert property (@(posedge i_clk)
        disable iff (i_srst) !(sta_oe && dev_oe))
        else $error("both ends drive the data line");
    dev_edge_a: assert property (@(posedge i_clk)
        disable iff (i_srst) ($changed(dev_o) || $changed(dev_oe)) |-> mdc)
        else $error("device output moved away from a clock rise");
    ta_zero_a: assert property (@(posedge i_clk)
        disable iff (i_srst) $rose(dev_oe) |-> !dev_o)
        else $error("turnaround bit from device is not zero");
    read_turn_a: assert property (@(posedge i_clk)
        disable iff (i_srst) $rose(dev_oe) |-> rise_cnt_q == 7'h2E && !sta_oe)
        else $error("device took the line at the wrong bit");
    data_hold_a: assert property (@(posedge mdc)
        disable iff (i_srst) $rose(dev_oe) |=> data_hold_s)
        else $error("device drive length is not seventeen bits");
    mdc_high_a: assert property (@(posedge i_clk)
        disable iff (i_srst) $rose(mdc) |=> mdc_high_s)
        else $error("management clock high phase wrong");
    mdc_low_a: assert property (@(posedge i_clk)
        disable iff (i_srst) $fell(mdc) |=> !mdc [*3])
        else $error("management clock low phase too short");
    sta_change_a: assert property (@(posedge i_clk)
        disable iff (i_srst) ($changed(sta_o) || $changed(sta_oe)) |-> !mdc)
        else $error("station output moved while clock high");
    preamble_a: assert property (@(posedge mdc)
        disable iff (i_srst) $rose(sta_oe) |-> sta_o [*8])
        else $error("frame does not open with ones");
endmodule : mms_props

// *** test/testbench.sv ***
// Self-checking bench joining the station and device ends
`timescale 1ns/1ps
module testbench;
    import mms_pkg::*;

    // ********************
    // Settings and signals
    // ********************
    localparam logic [4:0]  DEV_PHY  = 5'h01;
    localparam logic [15:0] TB_ID_HI = 16'h1234; // Arbitrary value
    localparam logic [15:0] TB_ID_LO = 16'h5678; // Arbitrary value
    localparam logic [15:0] STAT_VAL = 16'h3C5A;
    localparam logic [4:0]  STORED [5] =
        '{REG_CTRL, 5'h04, REG_STD_LAST, REG_VND_A, REG_VND_B};

    logic        i_clk;
    logic        i_srst;
    logic        i_start;
    logic        i_write;
    logic [4:0]  i_phy;
    logic [4:0]  i_reg;
    logic [15:0] i_wdata;
    logic [15:0] i_stat;
    logic        o_ready;
    logic        o_done;
    logic [15:0] o_rdata;
    logic        o_wr_valid;
    logic [4:0]  o_wr_reg;
    logic [15:0] o_wr_data;
    int          error_cnt;
    int          checks;
    int          wv_cnt = 0;
    logic [4:0]  wv_reg;
    logic [15:0] wv_data;

    mms_if link_if ();

    mms_station #(.MDC_DIV(MDC_DIV_CYC)) mms_station_inst (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_start (i_start),
        .i_write (i_write),
        .i_phy   (i_phy),
        .i_reg   (i_reg),
        .i_wdata (i_wdata),
        .o_ready (o_ready),
        .o_done  (o_done),
        .o_rdata (o_rdata),
        .link    (link_if)
    );

    mms_device #(.PHY_ADDR(DEV_PHY), .ID_HI(TB_ID_HI), .ID_LO(TB_ID_LO))
    mms_device_inst (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .link       (link_if),
        .i_stat     (i_stat),
        .o_wr_valid (o_wr_valid),
        .o_wr_reg   (o_wr_reg),
        .o_wr_data  (o_wr_data)
    );

    mms_props mms_props_inst (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .mdc    (link_if.mdc),
        .sta_o  (link_if.sta_o),
        .sta_oe (link_if.sta_oe),
        .dev_o  (link_if.dev_o),
        .dev_oe (link_if.dev_oe)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // Catches the one-cycle write pulse wherever it falls
    always @(posedge i_clk) begin
        if (o_wr_valid === 1'b1) begin
            wv_cnt  <= wv_cnt + 1;
            wv_reg  <= o_wr_reg;
            wv_data <= o_wr_data;
        end
    end

    // ********************
    // Tasks
    // ********************
    task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : cmp

    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // One frame; the answer must come a fixed span after the taking edge
    task automatic frame(input logic wr, input logic [4:0] phy,
                         input logic [4:0] rg, input logic [15:0] wd,
                         output logic [15:0] rd);
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 1000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        @(posedge i_clk);
        i_start <= 1'b1;
        i_write <= wr;
        i_phy   <= phy;
        i_reg   <= rg;
        i_wdata <= wd;
        @(posedge i_clk);
        i_start <= 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 1000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        cmp(16'h0200, 16'(n));
        rd = o_rdata;
    endtask : frame

    task automatic wr_chk(input logic [4:0] phy, input logic [4:0] rg,
                          input logic [15:0] wd, input logic hit);
        logic [15:0] rd;
        int          c0;
        c0 = wv_cnt;
        frame(1'b1, phy, rg, wd, rd);
        repeat (16) @(posedge i_clk);
        #1;
        if (wv_cnt != c0) begin
            cmp({11'h000, rg}, {11'h000, wv_reg});
            cmp(wd, wv_data);
        end
        cmp({15'h0000, hit}, 16'(wv_cnt - c0));
    endtask : wr_chk

    task automatic rd_chk(input logic [4:0] phy, input logic [4:0] rg,
                          input logic [15:0] exp);
        logic [15:0] rd;
        frame(1'b0, phy, rg, 16'h0000, rd);
        cmp(exp, rd);
    endtask : rd_chk

    // ********************
    // Main sequence and watchdog
    // ********************
    initial begin
        i_srst    = 1'b1;
        i_start   = 1'b0;
        i_write   = 1'b0;
        i_phy     = 5'h00;
        i_reg     = 5'h00;
        i_wdata   = 16'h0000;
        i_stat    = STAT_VAL;
        error_cnt = 0;
        checks    = 0;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        // First frame wakes the device's link reset and is not answered
        rd_chk(5'h02, REG_CTRL, 16'hFFFF);
        for (int k = 0; k < 5; k++) begin
            wr_chk(DEV_PHY, STORED[k], 16'hA5C0 ^ {11'h000, STORED[k]},
                   1'b1);
        end
        for (int k = 0; k < 5; k++) begin
            rd_chk(DEV_PHY, STORED[k],
                   16'hA5C0 ^ {11'h000, STORED[k]});
        end
        // Read-only and unmapped places
        wr_chk(DEV_PHY, REG_STAT, 16'hFFFF, 1'b0);
        wr_chk(DEV_PHY, REG_ID_HI, 16'h0000, 1'b0);
        wr_chk(DEV_PHY, 5'h06, 16'h1234, 1'b0);
        rd_chk(DEV_PHY, REG_STAT, STAT_VAL);
        rd_chk(DEV_PHY, REG_ID_HI, TB_ID_HI);
        rd_chk(DEV_PHY, REG_ID_LO, TB_ID_LO);
        rd_chk(DEV_PHY, 5'h06, 16'h0000);
        // Another PHY address: no drive, so the pull-up is read
        wr_chk(5'h02, REG_CTRL, 16'h0F0F, 1'b0);
        rd_chk(5'h02, REG_CTRL, 16'hFFFF);
        rd_chk(DEV_PHY, REG_CTRL, 16'hA5C0);
        print_verdict();
    end

    initial begin
        #(30000 * 25);
        error_cnt++;
        print_verdict();
    end
endmodule : testbench
